// ===== mcs_eng.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// measurement engine model
// ------------------------------------------
module mcs_eng
    import mcs_pkg::*;
#(
    parameter int LAT = 20
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // control in
    input  wire logic        init,
    input  wire logic        abort,
    input  wire logic [4:0]  ffunc,
    // status out
    output logic             busy,
    output logic             done,
    output logic [63:0]      result,
    output logic [3:0]       digits
);
    int cnt;
    // value names the fetched function, so a wrong derivation shows
    assign result = {56'h00_1234_5678_9abc, 3'h0, ffunc};
    assign digits = 4'h9;
    // abort ends a run without done, so no valid result is left behind
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            done <= 1'b0;
            cnt  <= 0;
        end else begin
            done <= busy && cnt == 1 && !abort;
            if (abort) begin
                busy <= 1'b0;
            end else if (init && !busy) begin
                busy <= 1'b1;
                cnt  <= LAT;
            end else if (busy) begin
                cnt  <= cnt - 1;
                busy <= cnt != 1;
            end
        end
    end
endmodule : mcs_eng
`default_nettype wire

// ===== mcs_fmt.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// result formatter
// ------------------------------------------
module mcs_fmt
    import mcs_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // result in
    input  wire logic        load,
    input  wire logic        nan,
    input  wire logic        real_fmt,
    input  wire logic [63:0] raw,
    input  wire logic [3:0]  digits,
    // result out
    output logic             valid,
    output logic [63:0]      data,
    output logic             is_real,
    output logic [3:0]       ndig
);
    // clamp the digit count; zero would give an empty mantissa
    wire [3:0] dig_lo = (digits < DIG_MIN) ? DIG_MIN : digits;
    wire [3:0] dig_ok = (dig_lo > DIG_MAX) ? DIG_MAX : dig_lo;

    // latch one answer per load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid   <= 1'b0;
            data    <= '0;
            is_real <= 1'b0;
            ndig    <= DIG_MIN;
        end else begin
            valid <= load;
            if (load) begin
                data    <= nan ? NAN_WORD : raw;
                is_real <= real_fmt;
                ndig    <= dig_ok; // RULE13
            end
        end
    end

    p_digits : assert property (@(posedge clk) disable iff (!rst_b)
        valid && !is_real |-> ndig >= DIG_MIN && ndig <= DIG_MAX)
        else $error("ascii digit count out of range"); // RULE13
endmodule : mcs_fmt
`default_nettype wire

// ===== mcs_pkg.sv
`default_nettype none
package mcs_pkg;
    // ------------------------------------------
    // command codes
    // ------------------------------------------
    localparam logic [2:0] OP_CONF   = 3'h0;
    localparam logic [2:0] OP_CONFQ  = 3'h1;
    localparam logic [2:0] OP_FETCH  = 3'h2;
    localparam logic [2:0] OP_MEAS   = 3'h3;
    localparam logic [2:0] OP_INIT   = 3'h4;
    localparam logic [2:0] OP_SENSE  = 3'h5;
    localparam logic [2:0] OP_RST    = 3'h6;
    localparam logic [2:0] OP_RECALL = 3'h7;
    // ------------------------------------------
    // function codes
    // ------------------------------------------
    localparam logic [4:0] F_DCYC = 5'h00;
    localparam logic [4:0] F_FTIM = 5'h01;
    localparam logic [4:0] F_FREQ = 5'h02;
    localparam logic [4:0] F_RAT  = 5'h03;
    localparam logic [4:0] F_MAX  = 5'h04;
    localparam logic [4:0] F_MIN  = 5'h05;
    localparam logic [4:0] F_NWID = 5'h06;
    localparam logic [4:0] F_PER  = 5'h07;
    localparam logic [4:0] F_PHAS = 5'h08;
    localparam logic [4:0] F_PTP  = 5'h09;
    localparam logic [4:0] F_PWID = 5'h0a;
    localparam logic [4:0] F_RTIM = 5'h0b;
    localparam logic [4:0] F_TINT = 5'h0c;
    localparam logic [4:0] F_TOTC = 5'h0d;
    localparam logic [4:0] F_TOTT = 5'h0e;
    localparam logic [4:0] F_PDUT = 5'h0f; // long spelling of duty cycle
    localparam logic [4:0] F_FALL = 5'h10; // long spelling of fall time
    localparam logic [4:0] F_RISE = 5'h11; // long spelling of rise time
    localparam logic [4:0] F_NONE = 5'h1f;
    // ------------------------------------------
    // defaults, errors, result words
    // ------------------------------------------
    localparam logic [31:0] DEF_REF   = 32'h0000_0032;
    localparam logic [31:0] DEF_LOWER = 32'h0000_000a;
    localparam logic [31:0] DEF_UPPER = 32'h0000_005a;
    localparam logic [31:0] DEF_GATE  = 32'h0000_000a;
    localparam logic [31:0] DEF_ZERO  = 32'h0000_0000;
    localparam logic [7:0]  CH_ONE    = 8'h10;
    localparam logic [7:0]  CH_PAIR   = 8'h12;
    localparam logic [15:0] ERR_STALE = 16'hff1a; // -230
    localparam logic [15:0] ERR_TOTAL = 16'hff23; // -221
    localparam logic [15:0] ERR_NOCFG = 16'hff38; // -200
    localparam logic [63:0] NAN_WORD  = 64'h47d2_a2c4_0000_0000;
    localparam logic [3:0]  DIG_MIN   = 4'h1;
    localparam logic [3:0]  DIG_MAX   = 4'hf;

    // fold long spellings onto the short ones
    function automatic logic [4:0] norm_f(input logic [4:0] f);
        case (f)
            F_PDUT:  norm_f = F_DCYC;
            F_FALL:  norm_f = F_FTIM;
            F_RISE:  norm_f = F_RTIM;
            default: norm_f = f;
        endcase
    endfunction : norm_f

    function automatic logic is_peak(input logic [4:0] f);
        is_peak = (f == F_MAX) || (f == F_MIN) || (f == F_PTP);
    endfunction : is_peak

    function automatic logic is_tot(input logic [4:0] f);
        is_tot = (f == F_TOTC) || (f == F_TOTT);
    endfunction : is_tot

    // result f is available from stored data of type m
    function automatic logic derivable(input logic [4:0] f, input logic [4:0] m);
        derivable = (f == m)
                 || ((f == F_FREQ || f == F_PER) && (m == F_FREQ || m == F_PER))
                 || (is_peak(f) && is_peak(m));
    endfunction : derivable
endpackage : mcs_pkg
`default_nettype wire

// ===== mcs_seq.sv
// Operation
// RULE1: configure sets up but never starts acquisition
// RULE2: omitted or default parameters take function defaults
// RULE3: configure resets settings; sense-select changes function only
// RULE4: configure and measure turn off post-processing
// RULE5: no absolute level: run auto-trigger, except peaks/totalize
// RULE6: config query reflects only configure or measure
// RULE7: config answer uses short function spellings
// RULE8: reset, recall, sense-select leave stored config
// RULE9: config query before any config: error, empty
// RULE10: fetch function must match or derive from type
// RULE11: unnamed fetch uses last used function
// RULE12: fetch during measurement stalls later commands
// RULE13: results in selected format, 1 to 15 digits
// RULE14: no valid result gives not-a-number and -230
// RULE15: fetch during auto totalize gives not-a-number, -221
// RULE16: measure configures, initiates, returns uninterrupted
// RULE17: measure aborts running measurement and stalls
// RULE18: valid flag cleared by setup, set on completion
`timescale 1ns/1ps
`default_nettype none
module mcs_seq
    import mcs_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // command port
    input  wire logic        CMD_VALID,
    output logic             CMD_READY,
    input  wire logic [2:0]  CMD_OP,
    input  wire logic [4:0]  CMD_FUNC,
    input  wire logic [1:0]  CMD_PGIVEN,
    input  wire logic [31:0] CMD_P1,
    input  wire logic [31:0] CMD_P2,
    input  wire logic        CMD_CGIVEN,
    input  wire logic [7:0]  CMD_CHAN,
    input  wire logic        CMD_ABSLVL,
    input  wire logic        DEV_CLEAR,
    input  wire logic        FMT_REAL,
    // measurement engine
    input  wire logic        ENG_BUSY,
    input  wire logic        ENG_DONE,
    input  wire logic [63:0] ENG_RESULT,
    input  wire logic [3:0]  ENG_DIGITS,
    output logic             ENG_CFG,
    output logic             ENG_DEFAULTS,
    output logic             ENG_SELECT,
    output logic             ENG_STATE_LOAD,
    output logic             ENG_INIT,
    output logic             ENG_ABORT,
    output logic [4:0]       ENG_FUNC,
    output logic [31:0]      ENG_P1,
    output logic [31:0]      ENG_P2,
    output logic [7:0]       ENG_CHAN,
    output logic [4:0]       ENG_FETCH_FUNC,
    // post-processing and trigger
    output logic             POST_OFF,
    output logic             AUTO_TRIG,
    // answers
    output logic             RSP_VALID,
    output logic [63:0]      RSP_DATA,
    output logic             RSP_REAL,
    output logic [3:0]       RSP_DIGITS,
    output logic             CFG_VALID,
    output logic             CFG_EMPTY,
    output logic [4:0]       CFG_FUNC,
    output logic [31:0]      CFG_P1,
    output logic [31:0]      CFG_P2,
    output logic [7:0]       CFG_CHAN,
    output logic             ERR_VALID,
    output logic [15:0]      ERR_CODE
);
    // ------------------------------------------
    // state
    // ------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_EXEC  = 6'b000010,
        S_ABORT = 6'b000100,
        S_CONF  = 6'b001000,
        S_WAIT  = 6'b010000,
        S_REPLY = 6'b100000
    } mcs_state_e;

    mcs_state_e  state;
    mcs_state_e  next_state;
    logic [2:0]  op;
    logic [4:0]  func;
    logic [1:0]  pgiven;
    logic [31:0] p1;
    logic [31:0] p2;
    logic        cgiven;
    logic [7:0]  chan;
    logic        abslvl;
    logic        cfg_have;
    logic [4:0]  meas_func;
    logic [4:0]  last_func;
    logic        res_valid;
    logic        fmt_load;
    logic        fmt_nan;

    // ------------------------------------------
    // decode
    // ------------------------------------------
    wire       in_idle  = (state == S_IDLE);
    wire       in_exec  = (state == S_EXEC);
    wire       in_conf  = (state == S_CONF);
    wire       in_wait  = (state == S_WAIT);
    wire       in_reply = (state == S_REPLY);
    wire       take     = in_idle && CMD_VALID;
    wire [4:0] nfunc    = norm_f(func);
    // a totalize run blocks fetch only while the engine is busy
    wire       tot_run  = ENG_BUSY && is_tot(meas_func);
    // unnamed fetch falls back to the last used function
    wire [4:0] ffunc    = (func == F_NONE) ? last_func : nfunc; // RULE11
    wire       can_get  = res_valid && derivable(ffunc, meas_func); // RULE10
    wire       no_auto  = abslvl || is_peak(nfunc) || is_tot(nfunc);

    // per-function defaults for both parameters and the channel
    wire [31:0] def1 =
        (nfunc == F_DCYC || nfunc == F_PWID || nfunc == F_NWID) ? DEF_REF :
        (nfunc == F_RTIM || nfunc == F_FTIM) ? DEF_LOWER :
        (nfunc == F_TOTT) ? DEF_GATE : DEF_ZERO;
    wire [31:0] def2 =
        (nfunc == F_RTIM || nfunc == F_FTIM) ? DEF_UPPER : DEF_ZERO;
    wire [7:0]  defc =
        (nfunc == F_RAT || nfunc == F_PHAS || nfunc == F_TINT) ? CH_PAIR : CH_ONE;
    // a missing or default parameter takes the function's value
    wire [31:0] use1 = pgiven[0] ? p1 : def1; // RULE2
    wire [31:0] use2 = pgiven[1] ? p2 : def2; // RULE2
    wire [7:0]  usec = cgiven ? chan : defc; // RULE2

    // commands are refused while an answer is pending
    assign CMD_READY = in_idle; // RULE12 RULE17

    // ------------------------------------------
    // sequencer
    // ------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:  if (CMD_VALID) next_state = S_EXEC;
            S_EXEC: begin
                case (op)
                    OP_CONF:  next_state = S_CONF;
                    OP_MEAS:  next_state = ENG_BUSY ? S_ABORT : S_CONF; // RULE17
                    OP_FETCH: next_state = tot_run ? S_IDLE : ENG_BUSY ? S_WAIT : S_REPLY;
                    default:  next_state = S_IDLE;
                endcase
            end
            // engine must idle before the new setup goes in
            S_ABORT: if (!ENG_BUSY) next_state = S_CONF;
            S_CONF:  next_state = (op == OP_MEAS) ? S_WAIT : S_IDLE; // RULE1 RULE16
            S_WAIT:  if (ENG_DONE) next_state = S_REPLY; // RULE12
            S_REPLY: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
        // device clear is the only way out besides completion
        if (DEV_CLEAR) next_state = S_IDLE;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) state <= S_IDLE;
        else        state <= next_state;
    end

    // latch the command when taken
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            op     <= OP_CONF;
            func   <= F_NONE;
            pgiven <= '0;
            p1     <= '0;
            p2     <= '0;
            cgiven <= 1'b0;
            chan   <= '0;
            abslvl <= 1'b0;
        end else if (take) begin
            op     <= CMD_OP;
            func   <= CMD_FUNC;
            pgiven <= CMD_PGIVEN;
            p1     <= CMD_P1;
            p2     <= CMD_P2;
            cgiven <= CMD_CGIVEN;
            chan   <= CMD_CHAN;
            abslvl <= CMD_ABSLVL;
        end
    end

    // ------------------------------------------
    // engine strobes
    // ------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ENG_CFG        <= 1'b0;
            ENG_DEFAULTS   <= 1'b0;
            ENG_SELECT     <= 1'b0;
            ENG_STATE_LOAD <= 1'b0;
            ENG_INIT       <= 1'b0;
            ENG_ABORT      <= 1'b0;
            POST_OFF       <= 1'b0;
            AUTO_TRIG      <= 1'b0;
            ENG_FUNC       <= F_NONE;
            ENG_P1         <= '0;
            ENG_P2         <= '0;
            ENG_CHAN       <= '0;
        end else begin
            ENG_CFG        <= in_conf && !DEV_CLEAR;
            ENG_DEFAULTS   <= in_conf && !DEV_CLEAR; // RULE3
            POST_OFF       <= in_conf && !DEV_CLEAR; // RULE4
            AUTO_TRIG      <= in_conf && !DEV_CLEAR && !no_auto; // RULE5
            // measure starts right after its setup; configure never does
            ENG_INIT       <= (in_conf && op == OP_MEAS && !DEV_CLEAR) // RULE16
                           || (in_exec && op == OP_INIT && !ENG_BUSY); // RULE1
            ENG_ABORT      <= in_exec && op == OP_MEAS && ENG_BUSY; // RULE17
            ENG_SELECT     <= in_exec && op == OP_SENSE; // RULE3
            ENG_STATE_LOAD <= in_exec && (op == OP_RST || op == OP_RECALL);
            if (in_conf || (in_exec && op == OP_SENSE)) begin
                ENG_FUNC <= nfunc;
            end
            if (in_conf) begin
                ENG_P1   <= use1;
                ENG_P2   <= use2;
                ENG_CHAN <= usec;
            end
        end
    end

    // ------------------------------------------
    // stored configuration and result state
    // ------------------------------------------
    // only configure and measure touch the stored config
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cfg_have <= 1'b0;
            CFG_FUNC <= F_NONE;
            CFG_P1   <= '0;
            CFG_P2   <= '0;
            CFG_CHAN <= '0;
        end else if (in_conf && !DEV_CLEAR) begin
            cfg_have <= 1'b1;
            CFG_FUNC <= nfunc; // RULE6 RULE7 RULE8
            CFG_P1   <= use1;
            CFG_P2   <= use2;
            CFG_CHAN <= usec;
        end
    end

    // measurement type follows setup and sense-select alike
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            meas_func <= F_NONE;
            last_func <= F_NONE;
        end else begin
            if (in_conf || (in_exec && op == OP_SENSE)) meas_func <= nfunc;
            if (in_conf) last_func <= nfunc;
            else if (in_reply && op == OP_FETCH) last_func <= ffunc; // RULE11
        end
    end

    // completion in the clearing cycle still counts
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B)          res_valid <= 1'b0;
        else if (ENG_DONE)   res_valid <= 1'b1; // RULE18
        else if (in_conf)    res_valid <= 1'b0; // RULE18
    end

    // ------------------------------------------
    // answers
    // ------------------------------------------
    wire tot_hit = in_exec && op == OP_FETCH && tot_run;
    wire cfgq    = in_exec && op == OP_CONFQ;
    wire bad     = in_reply && !can_get;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            fmt_load       <= 1'b0;
            fmt_nan        <= 1'b0;
            ENG_FETCH_FUNC <= F_NONE;
            CFG_VALID      <= 1'b0;
            CFG_EMPTY      <= 1'b0;
            ERR_VALID      <= 1'b0;
            ERR_CODE       <= '0;
        end else begin
            fmt_load  <= in_reply || tot_hit;
            fmt_nan   <= bad || tot_hit; // RULE14 RULE15
            if (in_exec) ENG_FETCH_FUNC <= ffunc;
            CFG_VALID <= cfgq;
            CFG_EMPTY <= cfgq && !cfg_have; // RULE9
            ERR_VALID <= bad || tot_hit || (cfgq && !cfg_have);
            if (tot_hit)                ERR_CODE <= ERR_TOTAL; // RULE15
            else if (bad)               ERR_CODE <= ERR_STALE; // RULE14
            else if (cfgq && !cfg_have) ERR_CODE <= ERR_NOCFG; // RULE9
        end
    end

    // result word held with the load, formatted one cycle later
    logic [63:0] raw_q;
    logic [3:0]  dig_q;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            raw_q <= '0;
            dig_q <= DIG_MIN;
        end else if (in_reply) begin
            raw_q <= ENG_RESULT;
            dig_q <= ENG_DIGITS;
        end
    end

    mcs_fmt u_fmt (
        .clk      (CLK_SYS),
        .rst_b    (RST_B),
        .load     (fmt_load),
        .nan      (fmt_nan),
        .real_fmt (FMT_REAL),
        .raw      (raw_q),
        .digits   (dig_q),
        .valid    (RSP_VALID),
        .data     (RSP_DATA),
        .is_real  (RSP_REAL),
        .ndig     (RSP_DIGITS)
    );

    // ------------------------------------------
    // checks
    // ------------------------------------------
    property p_conf_idle;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_conf && op == OP_CONF && !DEV_CLEAR |=> ENG_CFG && !ENG_INIT ##1 !ENG_INIT;
    endproperty
    a_conf_idle : assert property (p_conf_idle) // RULE1
        else $error("configure started acquisition");

    property p_post_off;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ENG_CFG |-> POST_OFF && ENG_DEFAULTS;
    endproperty
    a_post_off : assert property (p_post_off) // RULE4
        else $error("post-processing left on at setup");

    property p_auto;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_conf && !DEV_CLEAR |=> AUTO_TRIG == !$past(no_auto);
    endproperty
    a_auto : assert property (p_auto) // RULE5
        else $error("auto-trigger choice wrong");

    property p_cfg_keep;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !in_conf |=> $stable(CFG_FUNC) && $stable(CFG_P1);
    endproperty
    a_cfg_keep : assert property (p_cfg_keep) // RULE8
        else $error("stored config changed by other command");

    property p_cfg_empty;
        @(posedge CLK_SYS) disable iff (!RST_B)
        cfgq && !cfg_have |=> CFG_EMPTY && ERR_VALID && ERR_CODE == ERR_NOCFG;
    endproperty
    a_cfg_empty : assert property (p_cfg_empty) // RULE9
        else $error("early config query not flagged");

    property p_stale;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_reply && !res_valid |=> ERR_CODE == ERR_STALE ##1 RSP_VALID && RSP_DATA == NAN_WORD;
    endproperty
    a_stale : assert property (p_stale) // RULE14
        else $error("missing result not answered with nan");

    property p_tot;
        @(posedge CLK_SYS) disable iff (!RST_B)
        tot_hit |=> ERR_CODE == ERR_TOTAL ##1 RSP_VALID && RSP_DATA == NAN_WORD;
    endproperty
    a_tot : assert property (p_tot) // RULE15
        else $error("fetch during totalize not refused");

    property p_stall;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_wait && !ENG_DONE && !DEV_CLEAR |=> !CMD_READY;
    endproperty
    a_stall : assert property (p_stall) // RULE12
        else $error("commands taken during hold-off");

    property p_meas_abort;
        @(posedge CLK_SYS) disable iff (!RST_B)
        in_exec && op == OP_MEAS && ENG_BUSY && !DEV_CLEAR |=> ENG_ABORT && !CMD_READY;
    endproperty
    a_meas_abort : assert property (p_meas_abort) // RULE17
        else $error("measure did not abort running measurement");

    property p_valid_set;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ENG_DONE |=> res_valid;
    endproperty
    a_valid_set : assert property (p_valid_set) // RULE18
        else $error("completion lost");

    c_meas  : cover property (@(posedge CLK_SYS) disable iff (!RST_B)
        in_conf && op == OP_MEAS ##[1:50] RSP_VALID);
    c_fetch : cover property (@(posedge CLK_SYS) disable iff (!RST_B)
        in_wait ##[1:50] RSP_VALID && !fmt_nan);
    c_abort : cover property (@(posedge CLK_SYS) disable iff (!RST_B)
        ENG_ABORT ##[1:50] ENG_INIT);
endmodule : mcs_seq
`default_nettype wire

// ===== mcs_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_seq_test import mcs_pkg::*;;
    logic        clk_sys = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, abslvl = 1'b0, freal = 1'b0;
    logic [2:0]  cmd_op = 3'h0;
    logic [4:0]  cmd_func = 5'h1f, eng_func, ffunc, cfg_func;
    logic [1:0]  pgiven = 2'h0;
    logic [31:0] p1 = 32'h0000_0400, eng_p1, cfg_p1;
    logic [63:0] eng_result, rsp_data;
    logic [3:0]  eng_digits, rsp_digits;
    logic [15:0] err_code;
    logic        cmd_ready, eng_busy, eng_done, e_cfg, e_def, e_sel, e_ld, e_init, e_abort;
    logic        post_off, auto_trig, rsp_valid, rsp_real, cfg_valid, cfg_empty, err_valid;
    logic [10:0] seen = 11'h0;
    int          fail_count = 0, samples_checked = 0;
    always #5 clk_sys = ~clk_sys;
    mcs_seq dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_FUNC(cmd_func), .CMD_PGIVEN(pgiven),
        .CMD_P1(p1), .CMD_P2(p1), .CMD_CGIVEN(1'b0), .CMD_CHAN(8'h12), .CMD_ABSLVL(abslvl),
        .DEV_CLEAR(1'b0), .FMT_REAL(freal), .ENG_BUSY(eng_busy), .ENG_DONE(eng_done),
        .ENG_RESULT(eng_result), .ENG_DIGITS(eng_digits), .ENG_CFG(e_cfg),
        .ENG_DEFAULTS(e_def), .ENG_SELECT(e_sel), .ENG_STATE_LOAD(e_ld), .ENG_INIT(e_init),
        .ENG_ABORT(e_abort), .ENG_FUNC(eng_func), .ENG_P1(eng_p1), .ENG_P2(), .ENG_CHAN(),
        .ENG_FETCH_FUNC(ffunc), .POST_OFF(post_off), .AUTO_TRIG(auto_trig),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_REAL(rsp_real),
        .RSP_DIGITS(rsp_digits), .CFG_VALID(cfg_valid), .CFG_EMPTY(cfg_empty),
        .CFG_FUNC(cfg_func), .CFG_P1(cfg_p1), .CFG_P2(), .CFG_CHAN(),
        .ERR_VALID(err_valid), .ERR_CODE(err_code));
    mcs_eng #(.LAT(20)) eng_u (.clk(clk_sys), .rst_b(rst_b), .init(e_init), .abort(e_abort),
        .ffunc(ffunc), .busy(eng_busy), .done(eng_done), .result(eng_result),
        .digits(eng_digits));
    // sticky record of eleven pulses, all but cfg_empty and eng_done, zero at start and cleared before each run of commands that a check inspects
    always @(posedge clk_sys) seen <= seen | {e_def, e_sel, e_ld, e_cfg, e_init, e_abort,
        auto_trig, post_off, rsp_valid, err_valid, cfg_valid};
    function automatic logic [63:0] res(input logic [4:0] f);
        res = {56'h00_1234_5678_9abc, 3'h0, f};
    endfunction : res
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n
    // wait up to 200 cycles for ready before offering, so a refusal is not mistaken for a take
    task automatic cmd(input logic [2:0] op, input logic [4:0] fn, input logic [1:0] pg = 2'h0);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        cmd_op = op;
        cmd_func = fn;
        pgiven = pg;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask : cmd
    task automatic fetch(input logic [4:0] fn, input logic [10:0] es, input logic [63:0] ed);
        seen = 11'h0;
        cmd(OP_FETCH, fn);
        wait_n(40);
        chk("fetch pulses", {53'h0, es}, {53'h0, seen});
        chk("fetch data", ed, rsp_data);
    endtask : fetch
    task automatic t_first();
        cmd(OP_CONFQ, F_NONE);
        wait_n(1);
        chk("cfg empty", 64'h1, {63'h0, cfg_empty});
        wait_n(5);
        chk("cfg pulses", 64'h3, {53'h0, seen});
        chk("err code", {48'h0, ERR_NOCFG}, {48'h0, err_code});
        $display("test first done");
    endtask : t_first
    task automatic t_conf();
        seen = 11'h0;
        cmd(OP_CONF, F_PDUT);
        wait_n(30);
        chk("conf pulses", 64'h498, {53'h0, seen});
        chk("eng p1", {32'h0, DEF_REF}, {32'h0, eng_p1});
        fetch(F_NONE, 11'h006, NAN_WORD);
        chk("err code", {48'h0, ERR_STALE}, {48'h0, err_code});
        $display("test conf done");
    endtask : t_conf
    task automatic t_keep();
        seen = 11'h0;
        cmd(OP_SENSE, F_PER);
        cmd(OP_RST, F_NONE);
        cmd(OP_RECALL, F_NONE);
        cmd(OP_CONFQ, F_NONE);
        wait_n(8);
        chk("keep pulses", 64'h301, {53'h0, seen});
        chk("cfg func", {59'h0, F_DCYC}, {59'h0, cfg_func});
        chk("cfg p1", {32'h0, DEF_REF}, {32'h0, cfg_p1});
        $display("test keep done");
    endtask : t_keep
    task automatic t_meas();
        seen = 11'h0;
        freal = 1'b1;
        abslvl = 1'b1;
        cmd(OP_MEAS, F_FREQ, 2'h3);
        wait_n(40);
        abslvl = 1'b0;
        chk("meas pulses", 64'h4cc, {53'h0, seen});
        chk("eng p1", {32'h0, p1}, {32'h0, eng_p1});
        chk("meas data", res(F_FREQ), rsp_data);
        chk("real", 64'h1, {63'h0, rsp_real});
        chk("digits", 64'h9, {60'h0, rsp_digits});
        freal = 1'b0;
        fetch(F_PER, 11'h004, res(F_PER));
        chk("real", 64'h0, {63'h0, rsp_real});
        fetch(F_NONE, 11'h004, res(F_PER));
        fetch(F_MIN, 11'h006, NAN_WORD);
        seen = 11'h0;
        cmd(OP_MEAS, F_PTP);
        wait_n(40);
        chk("peak pulses", 64'h4cc, {53'h0, seen});
        fetch(F_MAX, 11'h004, res(F_MAX));
        $display("test meas done");
    endtask : t_meas
    task automatic t_busy();
        cmd(OP_INIT, F_NONE);
        wait_n(3);
        seen = 11'h0;
        cmd(OP_FETCH, F_NONE);
        wait_n(4);
        chk("ready stall", 64'h0, {63'h0, cmd_ready});
        wait_n(30);
        chk("stall pulses", 64'h004, {53'h0, seen});
        cmd(OP_INIT, F_NONE);
        wait_n(3);
        seen = 11'h0;
        cmd(OP_MEAS, F_PER);
        wait_n(60);
        chk("abort pulses", 64'h4fc, {53'h0, seen});
        chk("abort data", res(F_PER), rsp_data);
        $display("test busy done");
    endtask : t_busy
    task automatic t_total();
        cmd(OP_CONF, F_TOTT);
        cmd(OP_INIT, F_NONE);
        wait_n(2);
        fetch(F_NONE, 11'h006, NAN_WORD);
        chk("err code", {48'h0, ERR_TOTAL}, {48'h0, err_code});
        $display("test total done");
    endtask : t_total
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    initial begin
        wait_n(12);
        rst_b = 1'b1;
        t_first();
        t_conf();
        t_keep();
        t_meas();
        t_busy();
        t_total();
        print_verdict();
    end
    // watchdog, far beyond the cycles the tests need
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule : mcs_seq_test
`default_nettype wire
